// *** hdl/spm_pkg.sv ***
// Package for the shared pin function mux: pin indices, function selects and carrier structs.
// Assumes one clock domain; peripheral controllers sit on the core side of this mux.
package spm_pkg;

  // ------------------------------------------------------------------
  // Pin indices
  // ------------------------------------------------------------------
  localparam int NUM_PINS = 7;
  localparam int PIN_TDO = 0;
  localparam int PIN_B0 = 1;
  localparam int PIN_B1 = 2;
  localparam int PIN_B2 = 3;
  localparam int PIN_B3 = 4;
  localparam int PIN_A0 = 5;
  localparam int PIN_A4 = 6;

  // ------------------------------------------------------------------
  // Function select codes (per pin, two bits)
  // ------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SPM_FN_GPIO = 2'h0,
    SPM_FN_ALT1 = 2'h1,
    SPM_FN_ALT2 = 2'h2
  } spm_fn_e;

  // Reset value of the select bank: every pin in its port function, except the test data output pin, which carries test output.
  localparam logic [2*NUM_PINS-1:0] SEL_RESET = 14'h0000;
  // Pull-ups default on for every port-function pin.
  localparam logic [NUM_PINS-1:0] PULL_RESET = 7'h7f;

  // Three-signal view of all pins, one bit per pin in each signal.
  typedef struct packed
  {
    logic [NUM_PINS-1:0] o;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pu;
  } spm_pad_s;

  // Port function controls from the port registers.
  typedef struct packed
  {
    logic [NUM_PINS-1:0] dout;
    logic [NUM_PINS-1:0] dir;
  } spm_gpio_s;

  // Peripheral-side signals that drive pins.
  typedef struct packed
  {
    logic tdo;
    logic tap_shift;
    logic spi_master;
    logic spi_sclk_o;
    logic spi_mosi_o;
    logic spi_miso_o;
    logic scl_oe;
    logic sda_oe;
    logic t2_o;
    logic t2_oe;
    logic t3_o;
    logic t3_oe;
    logic pwm_output_zero;
  } spm_periph_s;

  // Pin inputs routed back to peripherals, after synchronising.
  typedef struct packed
  {
    logic spi_sclk_i;
    logic spi_ss_n;
    logic spi_miso_i;
    logic spi_mosi_i;
    logic scl_i;
    logic sda_i;
    logic t2_i;
    logic t3_i;
  } spm_route_s;

endpackage : spm_pkg

// *** hdl/spm_mux.sv ***
// Shared pin function mux for the test data output pin and port B/A shared pins.
// Assumes pins arrive asynchronously, the tap clock TCK is seen as a pin sampled on clock,
// and the pad ring resolves the wire from output, enable and pull-up.
`timescale 1ns/1ns

// What this block does
// - During reset every port-function pin is an input with pull-up on.
// - After reset port B lines 0-3 and port A line 0 are port pins.
// - Each port pin is individually an input or an output.
// - Alternate routing comes from the system integration select bank.
// - Test data output pin defaults to test output; port D line 1 optional.
// - Test data output driven only in Shift-IR or Shift-DR.
// - Test data output changes only on falling test clock edges.
// - SPI clock pin drives in master mode, receives in slave mode.
// - External master asserts slave select to address this slave.
// - Slave MISO floats when deselected; MISO is input in master mode.
// - Slave presents MISO half a clock before master samples it.
// - Master presents MOSI half a clock early; master drives, slave receives.
// - Port B line 0 carries I2C clock, line 1 I2C data or slave select.
// - Timer channel two sits on port B line 2 or port A line 4.
// - Port A line 0 alternatively carries output-only pwm output zero.
// - Test data input sampled on rising test clock edges by default.
module spm_mux
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [2*spm_pkg::NUM_PINS-1:0] sel,
  input wire spm_pkg::spm_gpio_s gpio,
  input wire spm_pkg::spm_periph_s periph,
  input wire logic [spm_pkg::NUM_PINS-1:0] pad_i,
  input wire logic tck_pin,
  input wire logic tdi_pin,
  output spm_pkg::spm_pad_s pad,
  output logic [spm_pkg::NUM_PINS-1:0] gpio_din,
  output spm_pkg::spm_route_s route,
  output logic tdi_bit,
  output logic tdi_valid
);
  import spm_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [1:0] tck_s;
    logic tck_prev;
    logic [1:0] tdi_s;
    logic tdo_q;
    spm_pad_s pad;
    logic [NUM_PINS-1:0] din;
    spm_route_s route;
    logic tdi_bit;
    logic tdi_valid;
  } spm_state_s;

  spm_state_s st;
  spm_state_s next_st;

  // Select field of one pin.
  function automatic spm_fn_e fn_of(input logic [2*NUM_PINS-1:0] s, input int idx);
    fn_of = spm_fn_e'(s[2*idx +: 2]);
  endfunction : fn_of

  // Test clock edge strobes, decoded from the synchronised pin.
  logic tck_fall;
  logic tck_rise;
  logic miso_drive;

  // Only the second stage of each synchroniser feeds the edge logic.
  assign tck_fall = st.tck_prev & ~st.tck_s[1];
  assign tck_rise = ~st.tck_prev & st.tck_s[1];
  // Slave drives MISO only while selected; the select line is the synchronised pin.
  // That costs about three clocks of release latency after the pin rises, but a
  // metastable select can never glitch the MISO driver.
  assign miso_drive = ~periph.spi_master & ~st.sync2[PIN_B1];

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // Each pin starts from its port function, then the selected alternate overrides it.
  // Pull-ups are dropped whenever anything may drive, so a pull never fights a driver.
  always_comb
  begin
    next_st = st;
    next_st.sync1 = pad_i;
    next_st.sync2 = st.sync1;
    next_st.tck_s = {st.tck_s[0], tck_pin};
    next_st.tck_prev = st.tck_s[1];
    next_st.tdi_s = {st.tdi_s[0], tdi_pin};
    next_st.din = st.sync2;
    next_st.tdi_valid = 1'b0;
    // Port function for all pins.
    for (int i = 0; i < NUM_PINS; i++)
    begin
      next_st.pad.o[i] = gpio.dout[i];
      next_st.pad.oe[i] = gpio.dir[i];
      next_st.pad.pu[i] = ~gpio.dir[i];
    end
    // Test data output moves only on a falling test clock.
    if (tck_fall)
    begin
      next_st.tdo_q = periph.tdo;
    end
    // Test data input taken on a rising test clock.
    if (tck_rise)
    begin
      next_st.tdi_bit = st.tdi_s[1];
      next_st.tdi_valid = 1'b1;
    end
    if (fn_of(sel, PIN_TDO) != SPM_FN_ALT1)
    begin
      next_st.pad.o[PIN_TDO] = next_st.tdo_q;
      next_st.pad.oe[PIN_TDO] = periph.tap_shift;
      next_st.pad.pu[PIN_TDO] = 1'b0;
    end
    // Port B line 0: SPI clock or I2C clock.
    case (fn_of(sel, PIN_B0))
      SPM_FN_ALT1:
      begin
        next_st.pad.o[PIN_B0] = periph.spi_sclk_o;
        next_st.pad.oe[PIN_B0] = periph.spi_master;
        next_st.pad.pu[PIN_B0] = 1'b0;
      end
      SPM_FN_ALT2:
      begin
        next_st.pad.o[PIN_B0] = 1'b0;
        next_st.pad.oe[PIN_B0] = periph.scl_oe;
        next_st.pad.pu[PIN_B0] = 1'b0;
      end
      default:
      begin
      end
    endcase
    // Port B line 1: slave select input or I2C data.
    case (fn_of(sel, PIN_B1))
      SPM_FN_ALT1:
      begin
        next_st.pad.oe[PIN_B1] = 1'b0;
        next_st.pad.pu[PIN_B1] = 1'b1;
      end
      SPM_FN_ALT2:
      begin
        next_st.pad.o[PIN_B1] = 1'b0;
        next_st.pad.oe[PIN_B1] = periph.sda_oe;
        next_st.pad.pu[PIN_B1] = 1'b0;
      end
      default:
      begin
      end
    endcase
    // Port B line 2: MISO or timer channel two.
    case (fn_of(sel, PIN_B2))
      SPM_FN_ALT1:
      begin
        next_st.pad.o[PIN_B2] = periph.spi_miso_o;
        next_st.pad.oe[PIN_B2] = miso_drive;
        next_st.pad.pu[PIN_B2] = 1'b0;
      end
      SPM_FN_ALT2:
      begin
        next_st.pad.o[PIN_B2] = periph.t2_o;
        next_st.pad.oe[PIN_B2] = periph.t2_oe;
        next_st.pad.pu[PIN_B2] = 1'b0;
      end
      default:
      begin
      end
    endcase
    // Port B line 3: MOSI or timer channel three.
    case (fn_of(sel, PIN_B3))
      SPM_FN_ALT1:
      begin
        next_st.pad.o[PIN_B3] = periph.spi_mosi_o;
        next_st.pad.oe[PIN_B3] = periph.spi_master;
        next_st.pad.pu[PIN_B3] = 1'b0;
      end
      SPM_FN_ALT2:
      begin
        next_st.pad.o[PIN_B3] = periph.t3_o;
        next_st.pad.oe[PIN_B3] = periph.t3_oe;
        next_st.pad.pu[PIN_B3] = 1'b0;
      end
      default:
      begin
      end
    endcase
    // Port A line 0: output-only PWM.
    if (fn_of(sel, PIN_A0) == SPM_FN_ALT1)
    begin
      next_st.pad.o[PIN_A0] = periph.pwm_output_zero;
      next_st.pad.oe[PIN_A0] = 1'b1;
      next_st.pad.pu[PIN_A0] = 1'b0;
    end
    // Port A line 4: second home of timer channel two.
    if (fn_of(sel, PIN_A4) == SPM_FN_ALT2)
    begin
      next_st.pad.o[PIN_A4] = periph.t2_o;
      next_st.pad.oe[PIN_A4] = periph.t2_oe;
      next_st.pad.pu[PIN_A4] = 1'b0;
    end
    // Every peripheral input comes from the second synchroniser stage only.
    // Inputs back to the peripherals; timer two follows whichever pin holds it.
    next_st.route.spi_sclk_i = st.sync2[PIN_B0];
    next_st.route.scl_i = st.sync2[PIN_B0];
    next_st.route.spi_ss_n = st.sync2[PIN_B1];
    next_st.route.sda_i = st.sync2[PIN_B1];
    next_st.route.spi_miso_i = st.sync2[PIN_B2];
    next_st.route.spi_mosi_i = st.sync2[PIN_B3];
    next_st.route.t3_i = st.sync2[PIN_B3];
    next_st.route.t2_i = (fn_of(sel, PIN_A4) == SPM_FN_ALT2) ? st.sync2[PIN_A4] : st.sync2[PIN_B2];
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Reset parks every pin as a pulled-up input; the test output floats.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st <= '0;
      st.pad.pu <= PULL_RESET;
      st.pad.pu[PIN_TDO] <= 1'b0;
      st.route.spi_ss_n <= 1'b1;
      // The test clock stages start at the idle high level, so no false edge follows reset.
      st.tck_s <= '1;
      st.tck_prev <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign pad = st.pad;
  assign gpio_din = st.din;
  assign route = st.route;
  assign tdi_bit = st.tdi_bit;
  assign tdi_valid = st.tdi_valid;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_reset_pullup: assert property (@(posedge clock) rst |=> (pad.oe[PIN_A0] == 1'b0) && pad.pu[PIN_A0])
    else $error("Pin not a pulled-up input after reset.");
  a_gpio_default: assert property (@(posedge clock) disable iff (rst)
      ($past(sel) == SEL_RESET) && !$past(rst) |-> pad.oe[PIN_B0] == $past(gpio.dir[PIN_B0]))
    else $error("Port B line 0 left its port function at default select.");
  a_gpio_dir: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_A4) == SPM_FN_GPIO |=> pad.oe[PIN_A4] == $past(gpio.dir[PIN_A4]))
    else $error("Port A line 4 direction does not follow its port setting.");
  a_tdo_shift: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_TDO) == SPM_FN_GPIO |=> pad.oe[PIN_TDO] == $past(periph.tap_shift))
    else $error("Test output driven outside a shift state.");
  a_tdo_fall: assert property (@(posedge clock) disable iff (rst)
      !tck_fall |=> st.tdo_q == $past(st.tdo_q))
    else $error("Test output changed without a falling test clock.");
  a_sclk_dir: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_B0) == SPM_FN_ALT1 |=> pad.oe[PIN_B0] == $past(periph.spi_master))
    else $error("SPI clock direction wrong for mode.");
  a_miso_release: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_B2) == SPM_FN_ALT1 && st.sync2[PIN_B1] |=> !pad.oe[PIN_B2])
    else $error("MISO still driven one clock after deselect.");
  a_single_drive: assert property (@(posedge clock) disable iff (rst)
      ##1 ((pad.oe & pad.pu) == '0))
    else $error("Driver and pull-up both active on a pin.");

  // Alternate-function drive checks, then the test data input capture: each pin's driver, value and pull-up follow
  // the select and the peripheral one clock later, because the pad outputs are registered.
  a_tdo_port: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_TDO) == SPM_FN_ALT1 |=> pad.oe[PIN_TDO] == $past(gpio.dir[PIN_TDO]))
    else $error("Port D line 1 direction lost on the test output pin.");
  a_tdo_pull: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_TDO) != SPM_FN_ALT1 |=> !pad.pu[PIN_TDO])
    else $error("Pull-up left on while the test output owns its pin.");
  a_ss_input: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_B1) == SPM_FN_ALT1 |=> !pad.oe[PIN_B1])
    else $error("Slave select pin driven by the device.");
  a_miso_master: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_B2) == SPM_FN_ALT1 && periph.spi_master |=> !pad.oe[PIN_B2])
    else $error("MISO driven while the device is master.");
  a_mosi_dir: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_B3) == SPM_FN_ALT1 |=> (pad.oe[PIN_B3] == $past(periph.spi_master))
      && (pad.o[PIN_B3] == $past(periph.spi_mosi_o)))
    else $error("MOSI direction or value wrong for mode.");
  a_i2c_open: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_B0) == SPM_FN_ALT2 |=> !pad.o[PIN_B0] && (pad.oe[PIN_B0] == $past(periph.scl_oe)))
    else $error("I2C clock pin not driven as open drain.");
  a_timer_share: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_A4) == SPM_FN_ALT2 |=> (pad.oe[PIN_A4] == $past(periph.t2_oe)) && (pad.o[PIN_A4] == $past(periph.t2_o)))
    else $error("Timer channel two not carried on port A line 4.");
  a_pwm_drive: assert property (@(posedge clock) disable iff (rst)
      fn_of(sel, PIN_A0) == SPM_FN_ALT1 |=> pad.oe[PIN_A0] && (pad.o[PIN_A0] == $past(periph.pwm_output_zero)))
    else $error("Pwm output zero not driven on port A line 0.");
  a_tdi_rise: assert property (@(posedge clock) disable iff (rst)
      tck_rise |=> tdi_valid && (tdi_bit == $past(st.tdi_s[1])))
    else $error("Test data input not taken on a rising test clock.");

endmodule : spm_mux

// *** dv/spm_far_model.sv ***
// Far-side pin model: external SPI, I2C and test devices resolved onto the pins.
// Assumes the bench sets which pins it drives; design drive wins only without contention.
`timescale 1ns/1ns
module spm_far_model
(
  input wire logic clock,
  input wire spm_pkg::spm_pad_s pad,
  input wire logic [spm_pkg::NUM_PINS-1:0] ext_en,
  input wire logic [spm_pkg::NUM_PINS-1:0] ext_val,
  output logic [spm_pkg::NUM_PINS-1:0] pad_i
);
  import spm_pkg::*;
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] churn = '0;
  // A floating line keeps changing, so a stale value can never pass.
  always @(posedge clock)
    churn <= ~churn;
  // Two drivers at once give an unknown, which no check will accept.
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pad.oe[i] && ext_en[i])
        pad_i[i] = 1'bx;
      else if (pad.oe[i])
        pad_i[i] = pad.o[i];
      else if (ext_en[i])
        pad_i[i] = ext_val[i];
      else if (pad.pu[i])
        pad_i[i] = 1'b1;
      else
        pad_i[i] = churn[i];
    end
  end
endmodule : spm_far_model

// *** dv/spm_mux_test.sv ***
// Self-checking bench for the shared pin mux.
// Assumes the far-side model resolves every pin from all drivers.
`timescale 1ns/1ns
module spm_mux_test;
  import spm_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2*NUM_PINS-1:0] sel = '0;
  spm_gpio_s gpio = '0;
  spm_periph_s periph = '0;
  logic [NUM_PINS-1:0] pad_i;
  logic [NUM_PINS-1:0] gpio_din;
  logic [NUM_PINS-1:0] ext_en = '0;
  logic [NUM_PINS-1:0] ext_val = '0;
  logic tck_pin = 1'b1;
  logic tdi_pin = 1'b0;
  logic tdi_bit;
  logic tdi_valid;
  spm_pad_s pad;
  spm_route_s route;
  int mismatches = 0;
  int checks = 0;

  spm_mux u_dut (.clock(clock), .rst(rst), .sel(sel), .gpio(gpio), .periph(periph), .pad_i(pad_i),
    .tck_pin(tck_pin), .tdi_pin(tdi_pin), .pad(pad), .gpio_din(gpio_din), .route(route),
    .tdi_bit(tdi_bit), .tdi_valid(tdi_valid));
  spm_far_model u_far (.clock(clock), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));

  // Free-running 25 MHz clock.
  initial
    forever #20 clock = ~clock;

  task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Sample just after the edge, once the design's updates have landed.
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : w

  task automatic t_port;
    @(posedge clock);
    gpio <= '{dout: 7'h2a, dir: 7'h5a};
    ext_en <= 7'h24;
    ext_val <= 7'h04;
    w(4);
    chk("port oe", 7'h5a, pad.oe & 7'h7e);
    chk("port out", 7'h0a, pad.o & 7'h5a);
    chk("port in", 7'h04, gpio_din & 7'h24);
    @(posedge clock);
    ext_en <= 7'h00;
    gpio.dir <= 7'h24;
    w(2);
    chk("port oe swap", 7'h24, pad.oe & 7'h7e);
  endtask : t_port

  task automatic t_tdo;
    @(posedge clock);
    gpio <= '{dout: 7'h00, dir: 7'h01};
    periph.tdo <= 1'b1;
    w(6);
    chk("tdo idle oe", 7'h00, {6'h0, pad.oe[0]});
    chk("tdo held", 7'h00, {6'h0, pad.o[0]});
    @(posedge clock);
    periph.tap_shift <= 1'b1;
    tck_pin <= 1'b0;
    w(6);
    chk("tdo shift oe", 7'h01, {6'h0, pad.oe[0]});
    chk("tdo fall", 7'h01, {6'h0, pad.o[0]});
    @(posedge clock);
    tck_pin <= 1'b1;
    periph.tdo <= 1'b0;
    w(6);
    chk("tdo rise", 7'h01, {6'h0, pad.o[0]});
    @(posedge clock);
    sel <= 14'h0001;
    periph.tap_shift <= 1'b0;
    w(2);
    chk("port d oe", 7'h01, {6'h0, pad.oe[0]});
    chk("port d out", 7'h00, {6'h0, pad.o[0]});
  endtask : t_tdo

  task automatic t_spi;
    @(posedge clock);
    sel <= 14'h0154;
    gpio <= '0;
    periph <= '{spi_miso_o: 1'b1, default: 1'b0};
    ext_en <= 7'h16;
    ext_val <= 7'h10;
    w(5);
    chk("slave oe", 7'h08, pad.oe & 7'h1e);
    chk("slave miso", 7'h08, pad.o & 7'h08);
    chk("slave in", 7'h01, {4'h0, route.spi_sclk_i, route.spi_ss_n, route.spi_mosi_i});
    @(posedge clock);
    ext_val <= 7'h14;
    w(4);
    chk("deselect oe", 7'h00, pad.oe & 7'h08);
    @(posedge clock);
    ext_en <= 7'h0c;
    ext_val <= 7'h0c;
    periph <= '{spi_master: 1'b1, spi_sclk_o: 1'b1, spi_mosi_o: 1'b1, default: 1'b0};
    w(4);
    chk("master oe", 7'h12, pad.oe & 7'h1e);
    chk("master out", 7'h12, pad.o & 7'h12);
    chk("master miso", 7'h01, {6'h0, route.spi_miso_i});
  endtask : t_spi

  task automatic t_alt;
    @(posedge clock);
    sel <= 14'h0028;
    periph <= '{scl_oe: 1'b1, default: 1'b0};
    ext_en <= 7'h04;
    ext_val <= 7'h00;
    w(4);
    chk("i2c oe", 7'h02, pad.oe & 7'h06);
    chk("i2c out", 7'h00, pad.o & 7'h02);
    chk("i2c in", 7'h00, {5'h0, route.scl_i, route.sda_i});
    @(posedge clock);
    sel <= 14'h2680;
    ext_en <= 7'h00;
    periph <= '{t2_oe: 1'b1, t2_o: 1'b1, t3_oe: 1'b1, pwm_output_zero: 1'b1, default: 1'b0};
    w(2);
    chk("timer pwm oe", 7'h78, pad.oe & 7'h78);
    chk("timer pwm out", 7'h68, pad.o & 7'h78);
    chk("driven pu", 7'h00, pad.pu & 7'h78);
  endtask : t_alt

  task automatic t_tdi;
    int k;
    k = 0;
    @(posedge clock);
    tdi_pin <= 1'b1;
    tck_pin <= 1'b0;
    w(4);
    @(posedge clock);
    tck_pin <= 1'b1;
    while (tdi_valid !== 1'b1 && k < 8)
    begin
      w(1);
      k++;
    end
    chk("tdi valid", 7'h01, {6'h0, tdi_valid});
    chk("tdi bit", 7'h01, {6'h0, tdi_bit});
  endtask : t_tdi

  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Watchdog: the whole sequence needs well under 300 cycles.
  initial
  begin
    repeat (2000) @(posedge clock);
    mismatches++;
    results();
  end

  // Reset for 8 cycles, then each scenario in turn.
  initial
  begin
    w(4);
    chk("oe in reset", 7'h00, pad.oe);
    chk("pu in reset", 7'h7e, pad.pu);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_port();
    t_tdo();
    t_spi();
    t_alt();
    t_tdi();
    results();
  end
endmodule : spm_mux_test
